// >>> rtl/tsb_screen_ctrl.sv
// Output-area text buffer controller with print position and scrolling
//
// Functional notes
// - 57-line memory: 18 visible plus 39 above
// - Status 3 reports lines above screen
// - Screen addresses column 1..width, line 1..18
// - Column wraps after width, line increments
// - Line always relative to current screen top
// - Off-screen write scrolls, then lines rebase
// - Status 9 reports screen width
// - Line above 18 scrolls up on next write
// - Null off screen scrolls, overwrites only in show mode
// - Non-positive line scrolls down on next write
// - Line below one minus above flags error
// - Read starts at print position, advances it
// - Past last nonblank: line-feed with end flag
// - Trailing spaces are blanks, never returned
// - Wide variant skips enhancement codes on read
// - Mode change writes no announcement text
// - Show mode displays controls; CR also LF
// - Nonzero to control 4 enables show mode
`timescale 1ns/1ps
module tsb_screen_ctrl
    import tsb_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    // Clock, reset, enable
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    // Register access (control write, status read)
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_valid_o,
    output logic             reg_err_o,
    // Character output stream into the display
    input  wire logic        chr_wr_i,
    input  wire logic [7:0]  chr_data_i,
    // Character input stream read back from the display
    input  wire logic        chr_rd_i,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o,
    output logic             rd_eoi_o,
    // Screen clear request and busy
    input  wire logic        clear_i,
    output logic             busy_o
);
    import tsb_pkg::*;

    // Geometry derived from variant
    localparam int COLS  = WIDE ? WIDE_COLS : NARROW_COLS;
    localparam int DEPTH = TOTAL_LINES * COLS;
    localparam int AW    = $clog2(DEPTH);

    // Whole module state
    typedef struct packed {
        tsb_state_t        st;
        logic [6:0]        col;       // Print column, 1 based
        logic signed [7:0] line;      // Print line relative to top
        logic [5:0]        above;     // Lines above screen
        logic [5:0]        used;      // Buffer lines holding text, 18 min
        logic              show;      // Display-functions mode
        logic [7:0]        chr;       // Pending write character
        logic [6:0]        scan_col;  // Column probe during blank scan
        logic              nonblank;  // Nonblank seen at or past print column
        logic [AW-1:0]     clr_addr;  // Clear sweep address
        logic [15:0]       rdata;
        logic              rvalid;
        logic              rerr;
        logic [7:0]        odata;
        logic              ovalid;
        logic              oeoi;
        logic              busy;      // Registered busy flag
    } tsb_state_s_t;

    tsb_state_s_t  s_r;
    tsb_state_s_t  s_nxt;

    // Memory ports
    logic          mem_we;
    logic [AW-1:0] mem_waddr;
    logic [7:0]    mem_wdata;
    logic [AW-1:0] mem_raddr;
    logic [7:0]    mem_rdata;
    logic [5:0]    map_line;
    logic [6:0]    map_col;
    logic [AW-1:0] map_addr;

    initial
    begin
        if (COLS > 127) $error("tsb_screen_ctrl: width too large");
    end

    // Buffer line index of a screen-relative line
    function automatic logic [5:0] buf_line(input logic [5:0] above,
                                            input logic signed [7:0] rel);
        logic signed [8:0] v;
        v = 9'(signed'({3'b000, above})) + 9'(rel) - 9'sd1;
        return v[5:0];
    endfunction

    // Blank test for read-back: spaces, nulls and, in the wide variant, enhancement codes
    function automatic logic is_blank(input logic [7:0] c);
        return (c == CH_SPACE) || (c == CH_NUL) ||
               (WIDE && c >= CH_ENH_LO && c <= CH_ENH_HI);
    endfunction

    // Single address mapper shared by write, probe and read; clear drives its own address
    tsb_line_map #(
        .COLS     (COLS),
        .AW       (AW)
    ) u_map (
        .buf_line_i (map_line),
        .col_i      (map_col),
        .addr_o     (map_addr)
    );

    tsb_text_mem #(
        .DEPTH    (DEPTH),
        .AW       (AW)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .ce_i      (ce_i),
        .we_i      (mem_we),
        .waddr_i   (mem_waddr),
        .wdata_i   (mem_wdata),
        .raddr_i   (mem_raddr),
        .rdata_o   (mem_rdata)
    );

    // Next-state logic for the whole controller
    always_comb
    begin
        logic signed [8:0] lo;
        logic [5:0]        blin;
        logic [5:0]        top;
        lo        = 9'sd1 - 9'(signed'({3'b000, s_r.above}));
        blin      = 6'h00;
        top       = 6'h00;
        s_nxt     = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.ovalid = 1'b0;
        s_nxt.oeoi   = 1'b0;
        mem_we    = 1'b0;
        mem_wdata = s_r.chr;
        map_line  = buf_line(s_r.above, s_r.line);
        map_col   = 7'(s_r.col - 7'd1);
        mem_waddr = map_addr;
        mem_raddr = map_addr;

        case (s_r.st)
            ST_IDLE:
            begin
                // Register writes
                if (reg_wr_i)
                begin
                    case (reg_addr_i)
                        REG_COL:
                            if (reg_wdata_i >= 16'h0001 && reg_wdata_i <= 16'(COLS))
                                s_nxt.col = reg_wdata_i[6:0];
                            else
                                s_nxt.rerr = 1'b1;
                        REG_LINE:
                            // Legal range is 1-above up to past the bottom
                            if (18'(signed'(reg_wdata_i)) < 18'(lo) ||
                                signed'(reg_wdata_i) > 16'sd57)
                                s_nxt.rerr = 1'b1;
                            else
                                s_nxt.line = 8'(reg_wdata_i);
                        REG_SHOWCTL:
                            // Mode flip only, no text is emitted
                            s_nxt.show = |reg_wdata_i;
                        default:
                            s_nxt.rerr = 1'b1;
                    endcase
                end
                // Register reads
                else if (reg_rd_i)
                begin
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rerr   = 1'b0;
                    case (reg_addr_i)
                        REG_COL:     s_nxt.rdata = 16'(s_r.col);
                        REG_LINE:    s_nxt.rdata = 16'(signed'(s_r.line));
                        REG_ABOVE:   s_nxt.rdata = 16'(s_r.above);
                        REG_SHOWCTL: s_nxt.rdata = 16'(s_r.show);
                        REG_WIDTH:   s_nxt.rdata = 16'(COLS);
                        default:
                        begin
                            s_nxt.rdata = 16'h0000;
                            s_nxt.rerr  = 1'b1;
                        end
                    endcase
                end
                else if (clear_i)
                begin
                    s_nxt.clr_addr = '0;
                    s_nxt.st       = ST_CLEAR;
                end
                else if (chr_wr_i)
                begin
                    s_nxt.chr = chr_data_i;
                    // Wrap column before placing the character
                    if (s_r.col > 7'(COLS))
                    begin
                        s_nxt.col  = 7'd1;
                        s_nxt.line = s_r.line + 8'sd1;
                    end
                    s_nxt.st = ST_WRITE;
                end
                else if (chr_rd_i)
                begin
                    s_nxt.scan_col = s_r.col;
                    s_nxt.nonblank = 1'b0;
                    s_nxt.st       = ST_SCAN;
                end
            end

            ST_WRITE:
            begin
                // Scroll first so the print line lands on screen
                if (s_r.line > 8'(SCREEN_LINES))
                begin
                    top = 6'(32'(s_r.above) + 32'(s_r.line) - SCREEN_LINES);
                    if (top > 6'(EXTRA_LINES))
                        top = 6'(EXTRA_LINES);
                    s_nxt.above = top;
                    s_nxt.line  = 8'(SCREEN_LINES);
                    if (6'(32'(top) + SCREEN_LINES) > s_r.used)
                        s_nxt.used = 6'(32'(top) + SCREEN_LINES);
                end
                else if (s_r.line < 8'sd1)
                begin
                    s_nxt.above = buf_line(s_r.above, s_r.line);
                    s_nxt.line  = 8'sd1;
                end
                else
                begin
                    blin = buf_line(s_r.above, s_r.line);
                    map_line = blin;
                    mem_waddr = map_addr;
                    if (s_r.show || s_r.chr > CH_CTL_MAX)
                    begin
                        // Printable, or control shown in show mode
                        mem_we    = 1'b1;
                        s_nxt.col = s_r.col + 7'd1;
                        if (s_r.show && s_r.chr == CH_CR)
                        begin
                            s_nxt.col  = 7'd1;
                            s_nxt.line = s_r.line + 8'sd1;
                        end
                    end
                    else
                    begin
                        // Null and unlisted controls write nothing; BS, LF and CR act
                        case (s_r.chr)
                            CH_BS: if (s_r.col > 7'd1) s_nxt.col = s_r.col - 7'd1;
                            CH_LF: s_nxt.line = s_r.line + 8'sd1;
                            CH_CR: s_nxt.col = 7'd1;
                            default: ;
                        endcase
                    end
                    s_nxt.st = ST_IDLE;
                end
            end

            ST_SCAN:
            begin
                // Probe rest of line; last step refetches the print position
                map_col   = (s_r.scan_col > 7'(COLS)) ? 7'(s_r.col - 7'd1)
                                                     : 7'(s_r.scan_col - 7'd1);
                mem_raddr = map_addr;
                if (s_r.scan_col != s_r.col && !is_blank(mem_rdata))
                    s_nxt.nonblank = 1'b1;
                if (s_r.scan_col > 7'(COLS))
                    s_nxt.st = ST_READ;
                else
                    s_nxt.scan_col = s_r.scan_col + 7'd1;
            end

            ST_READ:
            begin
                // Print-position byte arrives now; fetch the next one for a skip
                map_col   = s_r.col;
                mem_raddr = map_addr;
                s_nxt.st  = ST_IDLE;
                blin      = buf_line(s_r.above, s_r.line);
                if (s_r.col <= 7'(COLS) && blin < s_r.used &&
                    (s_r.nonblank || !is_blank(mem_rdata)))
                begin
                    s_nxt.scan_col = s_r.col + 7'd1;
                    s_nxt.col      = s_r.col + 7'd1;
                    if (is_blank(mem_rdata) && mem_rdata != CH_SPACE)
                        s_nxt.st = ST_READ; // Skip; next column already fetched
                    else
                    begin
                        s_nxt.odata  = mem_rdata;
                        s_nxt.ovalid = 1'b1;
                    end
                end
                else
                begin
                    s_nxt.odata  = CH_LF;
                    s_nxt.ovalid = 1'b1;
                    s_nxt.oeoi   = 1'b1;
                    s_nxt.col    = 7'd1;
                    s_nxt.line   = s_r.line + 8'sd1;
                end
            end

            ST_CLEAR:
            begin
                // Sweep memory with spaces, then home position and scroll; show mode is kept
                mem_we    = 1'b1;
                mem_waddr = s_r.clr_addr;
                mem_wdata = CH_SPACE;
                if (32'(s_r.clr_addr) == DEPTH - 1)
                begin
                    s_nxt.above = RST_ABOVE;
                    s_nxt.used  = 6'(SCREEN_LINES);
                    s_nxt.col   = RST_COL[6:0];
                    s_nxt.line  = 8'(RST_LINE);
                    s_nxt.st    = ST_IDLE;
                end
                else
                    s_nxt.clr_addr = s_r.clr_addr + AW'(1);
            end

            default:
                s_nxt.st = ST_IDLE;
        endcase
        s_nxt.busy = (s_nxt.st != ST_IDLE); // Registered so the port has no decode
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_r          <= '0;
            s_r.st       <= ST_IDLE;
            s_r.col      <= RST_COL[6:0];
            s_r.line     <= 8'(RST_LINE);
            s_r.above    <= RST_ABOVE;
            s_r.used     <= 6'(SCREEN_LINES);
        end
        else if (ce_i)
            s_r <= s_nxt;
    end

    // Outputs straight from state flops
    assign reg_rdata_o = s_r.rdata;
    assign reg_valid_o = s_r.rvalid;
    assign reg_err_o   = s_r.rerr;
    assign rd_data_o   = s_r.odata;
    assign rd_valid_o  = s_r.ovalid;
    assign rd_eoi_o    = s_r.oeoi;
    assign busy_o      = s_r.busy;
endmodule // tsb_screen_ctrl

// >>> inc/tsb_pkg.sv
// Package of constants and types for the text screen buffer controller
package tsb_pkg;
    // Register numbers
    localparam logic [3:0]  REG_COL        = 4'h0;
    localparam logic [3:0]  REG_LINE       = 4'h1;
    localparam logic [3:0]  REG_ABOVE      = 4'h3;
    localparam logic [3:0]  REG_SHOWCTL    = 4'h4;
    localparam logic [3:0]  REG_WIDTH      = 4'h9;
    // Geometry
    localparam int          SCREEN_LINES   = 18;
    localparam int          EXTRA_LINES    = 39;
    localparam int          TOTAL_LINES    = 57;
    localparam int          NARROW_COLS    = 50;
    localparam int          WIDE_COLS      = 80;
    // Character codes
    localparam logic [7:0]  CH_NUL         = 8'h00;
    localparam logic [7:0]  CH_BS          = 8'h08;
    localparam logic [7:0]  CH_LF          = 8'h0A;
    localparam logic [7:0]  CH_CR          = 8'h0D;
    localparam logic [7:0]  CH_SPACE       = 8'h20;
    localparam logic [7:0]  CH_ENH_LO      = 8'h80;
    localparam logic [7:0]  CH_ENH_HI      = 8'h87;
    localparam logic [7:0]  CH_CTL_MAX     = 8'h1F;
    // Reset values
    localparam logic [15:0] RST_COL        = 16'h0001;
    localparam logic [15:0] RST_LINE       = 16'h0001;
    localparam logic [5:0]  RST_ABOVE      = 6'h00;
    // Controller states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WRITE = 5'b00010,
        ST_READ  = 5'b00100,
        ST_SCAN  = 5'b01000,
        ST_CLEAR = 5'b10000
    } tsb_state_t;
endpackage

// >>> rtl/tsb_text_mem.sv
// Text memory array: one write port, one registered read port
`timescale 1ns/1ps
module tsb_text_mem #(
    parameter int DEPTH = 4560,
    parameter int AW    = 13
) (
    // Clock
    input  wire logic          clk_sys_i,
    input  wire logic          ce_i,
    // Write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    // Read port
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    // Character storage; no reset so it maps to block memory
    logic [7:0] mem [DEPTH];

    initial
    begin
        if (DEPTH > (1 << AW)) $error("tsb_text_mem: AW too small");
    end

    // Synchronous write and read
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i)
        begin
            if (we_i)
                mem[waddr_i] <= wdata_i;
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // tsb_text_mem

// >>> rtl/tsb_line_map.sv
// Maps buffer line and column to a flat text memory address
`timescale 1ns/1ps
module tsb_line_map #(
    parameter int COLS = 80,
    parameter int AW   = 13
) (
    // Buffer coordinates, zero based
    input  wire logic [5:0]    buf_line_i,
    input  wire logic [6:0]    col_i,
    // Flat address
    output logic      [AW-1:0] addr_o
);
    // Line times width plus column
    always_comb
    begin
        addr_o = AW'(32'(buf_line_i) * COLS + 32'(col_i));
    end
endmodule // tsb_line_map

// >>> verification/tsb_screen_ctrl_asserts.sv
// Concurrent checks on the ports of the text screen buffer controller
`timescale 1ns/1ps
module tsb_screen_ctrl_asserts
    import tsb_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    // Clock, reset, enable
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    // Register access
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_valid_o,
    input wire logic        reg_err_o,
    // Character streams
    input wire logic        chr_wr_i,
    input wire logic [7:0]  chr_data_i,
    input wire logic        chr_rd_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        rd_valid_o,
    input wire logic        rd_eoi_o,
    // Clear and busy
    input wire logic        clear_i,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Width the block must report
    localparam logic [15:0] COLS_EXP = WIDE ? 16'h0050 : 16'h0032;
    // Accepted requests, in the block's priority order
    logic go, free, wr_go, rd_go, clr_go, cwr_go, crd_go;
    assign go     = ce_i && !busy_o;
    assign free   = go && !reg_wr_i && !reg_rd_i;
    assign wr_go  = go && reg_wr_i;
    assign rd_go  = go && !reg_wr_i && reg_rd_i;
    assign clr_go = free && clear_i;
    assign cwr_go = free && !clear_i && chr_wr_i;
    assign crd_go = free && !clear_i && !chr_wr_i && chr_rd_i;
    // A character write holds busy briefly, scrolls take one extra cycle
    sequence s_wr_busy; busy_o ##[1:3] !busy_o; endsequence
    property p_reg_answer; rd_go |=> reg_valid_o; endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("status read not answered");
    property p_reg_cause; reg_valid_o |-> $past(rd_go); endproperty
    a_reg_cause: assert property (p_reg_cause) else $error("answer without a read");
    property p_width; rd_go && reg_addr_i == REG_WIDTH |=> reg_rdata_o == COLS_EXP; endproperty
    a_width: assert property (p_width) else $error("screen width wrong");
    property p_above; rd_go && reg_addr_i == REG_ABOVE |=> reg_rdata_o <= 16'h0027; endproperty
    a_above: assert property (p_above) else $error("lines above screen too large");
    property p_line_err;
        wr_go && reg_addr_i == REG_LINE && $signed(reg_wdata_i) > 57 |=> reg_err_o;
    endproperty
    a_line_err: assert property (p_line_err) else $error("bad line not flagged");
    property p_eoi_lf; rd_eoi_o |-> rd_valid_o && rd_data_o == CH_LF; endproperty
    a_eoi_lf: assert property (p_eoi_lf) else $error("end flag without line-feed");
    property p_no_enh; rd_valid_o && WIDE |-> !(rd_data_o inside {[CH_ENH_LO:CH_ENH_HI]}); endproperty
    a_no_enh: assert property (p_no_enh) else $error("enhancement code read back");
    property p_rd_answer; crd_go |-> ##[1:200] rd_valid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read-back not answered");
    property p_wr_busy; cwr_go |=> s_wr_busy; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("character write timing");
    property p_clear; clr_go |=> busy_o [*8]; endproperty
    a_clear: assert property (p_clear) else $error("clear not held busy");
endmodule // tsb_screen_ctrl_asserts

bind tsb_screen_ctrl tsb_screen_ctrl_asserts #(.WIDE(WIDE)) u_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_valid_o(reg_valid_o), .reg_err_o(reg_err_o),
    .chr_wr_i(chr_wr_i), .chr_data_i(chr_data_i), .chr_rd_i(chr_rd_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .rd_eoi_o(rd_eoi_o), .clear_i(clear_i), .busy_o(busy_o));

// >>> verification/tsb_host_model.sv
// Host-side model issuing register, character and clear requests
`timescale 1ns/1ps
module tsb_host_model (
    // Clock and answers from the block
    input  wire logic        clk_i,
    input  wire logic        busy_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        valid_i,
    input  wire logic [7:0]  rd_data_i,
    input  wire logic        rd_valid_i,
    // Requests to the block
    output logic             ce_o,
    output logic      [4:0]  req_o,
    output logic      [3:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic      [7:0]  chr_o
);
    // Idle levels at time zero; enable stays on
    initial
    begin
        ce_o    = 1'b1;
        req_o   = 5'h00;
        addr_o  = 4'h0;
        wdata_o = 16'h0000;
        chr_o   = 8'h00;
    end
    // Busy requests are dropped silently, so always wait first
    task automatic idle();
        for (int i = 0; i < 6000 && busy_i; i++) @(posedge clk_i) #1;
    endtask
    // One-cycle request: reg write, reg read, char write, char read, clear
    task automatic req(input logic [4:0] r);
        // Let an edge pass so a lowered strobe is never raised in the same step
        @(posedge clk_i) #1;
        idle();
        req_o = r;
        @(posedge clk_i) #1;
        req_o = 5'h00;
    endtask
    // Line writes only move the position; the scroll waits
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        addr_o  = a;
        wdata_o = d;
        req(5'h10);
    endtask
    // Status read, answer one cycle after it is taken
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        addr_o = a;
        req(5'h08);
        for (int i = 0; i < 4 && !valid_i; i++) @(posedge clk_i) #1;
        d = valid_i ? rdata_i : 16'hXXXX; // No answer must fail the compare
    endtask
    task automatic chr_write(input logic [7:0] c);
        chr_o = c;
        req(5'h04);
    endtask
    // Read-back scans from the print column to the end of the line, so allow a long wait
    task automatic chr_read(output logic [7:0] d, output logic v);
        req(5'h02);
        for (int i = 0; i < 200 && !rd_valid_i; i++) @(posedge clk_i) #1;
        d = rd_data_i;
        v = rd_valid_i;
    endtask
    task automatic clear();
        req(5'h01);
        idle();
    endtask
endmodule // tsb_host_model

// >>> verification/tb_text_screen_buffer_controller.sv
// Self-checking bench for the text screen buffer controller
`timescale 1ns/1ps
module tb_text_screen_buffer_controller;
    import tsb_pkg::*;
    // Wide variant under test
    localparam bit WIDE = 1'b1;
    localparam int COLS = WIDE ? WIDE_COLS : NARROW_COLS;
    // Block wiring
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        ce, reg_valid, reg_err, rd_valid, eoi, busy;
    logic [4:0]  req;
    logic [3:0]  addr;
    logic [7:0]  chr, rd_data;
    logic [15:0] wdata, rdata, v;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    // Text with an enhancement code and trailing blanks
    logic [7:0]  txt [6] = '{8'h41, 8'h42, 8'h81, 8'h43, 8'h20, 8'h20};
    always #10 clk_sys = ~clk_sys;
    tsb_screen_ctrl #(.WIDE(WIDE)) uut (
        .clk_sys_i(clk_sys), .reset_n_i(reset_n), .ce_i(ce), .reg_wr_i(req[4]),
        .reg_rd_i(req[3]), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_valid_o(reg_valid), .reg_err_o(reg_err), .chr_wr_i(req[2]), .chr_data_i(chr),
        .chr_rd_i(req[1]), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_eoi_o(eoi),
        .clear_i(req[0]), .busy_o(busy));
    tsb_host_model host (
        .clk_i(clk_sys), .busy_i(busy), .rdata_i(rdata), .valid_i(reg_valid),
        .rd_data_i(rd_data), .rd_valid_i(rd_valid), .ce_o(ce), .req_o(req), .addr_o(addr),
        .wdata_o(wdata), .chr_o(chr));
    // Count and compare
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        host.reg_read(a, v);
        chk(what, exp, v);
    endtask
    // Read-back character, sampled with its end flag
    task automatic cchk(input logic [7:0] exp, input logic exp_eoi);
        logic [7:0] d;
        logic       ok;
        host.chr_read(d, ok);
        chk("read_char", {6'h00, 1'b1, exp_eoi, exp}, {6'h00, ok, ok && eoi, d});
    endtask
    task automatic pos(input logic [15:0] c, input logic [15:0] l);
        host.reg_write(REG_COL, c);
        host.reg_write(REG_LINE, l);
    endtask
    // A read first clears the sticky flag, then the write must set it
    task automatic bad_wr(input logic [3:0] a, input logic [15:0] d);
        host.reg_read(REG_ABOVE, v);
        host.reg_write(a, d);
        chk("reg_err", 16'h0001, {15'h0000, reg_err});
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far above the roughly 14500 cycles expected
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        @(posedge clk_sys) #1;
        rchk("col", REG_COL, 16'h0001);
        rchk("line", REG_LINE, 16'h0001);
        rchk("above", REG_ABOVE, 16'h0000);
        rchk("show", REG_SHOWCTL, 16'h0000);
        rchk("width", REG_WIDTH, 16'(COLS));
        host.clear();
        rchk("above", REG_ABOVE, 16'h0000);
        // Show mode: no text appears, carriage-return also feeds
        pos(16'h0001, 16'h0001);
        host.reg_write(REG_SHOWCTL, 16'h0005);
        host.reg_read(REG_SHOWCTL, v);
        chk("show_on", 16'h0001, {15'h0000, |v});
        rchk("col", REG_COL, 16'h0001);
        host.chr_write(CH_CR);
        rchk("col", REG_COL, 16'h0001);
        rchk("line", REG_LINE, 16'h0002);
        host.reg_write(REG_SHOWCTL, 16'h0000);
        rchk("show", REG_SHOWCTL, 16'h0000);
        // One character past the width wraps to the next line
        host.clear();
        pos(16'h0001, 16'h0001);
        repeat (COLS + 1) host.chr_write(8'h41);
        rchk("col", REG_COL, 16'h0002);
        rchk("line", REG_LINE, 16'h0002);
        // Scroll up four, then down one, then to the very top
        host.reg_write(REG_LINE, 16'h0016);
        host.chr_write(CH_NUL);
        rchk("above", REG_ABOVE, 16'h0004);
        rchk("line", REG_LINE, 16'h0012);
        host.reg_write(REG_LINE, 16'h0000);
        host.chr_write(CH_NUL);
        rchk("above", REG_ABOVE, 16'h0003);
        pos(16'h0001, 16'hFFFE);
        host.chr_write(CH_NUL);
        rchk("above", REG_ABOVE, 16'h0000);
        pos(16'h0001, 16'h0001);
        cchk(8'h41, 1'b0);
        rchk("col", REG_COL, 16'h0002);
        // Refused line values and an unmapped register
        bad_wr(REG_LINE, 16'h0000);
        bad_wr(REG_LINE, 16'h0040);
        bad_wr(4'h5, 16'h0001);
        // Read-back skips enhancement codes and trailing blanks
        host.clear();
        pos(16'h0001, 16'h0001);
        foreach (txt[i]) host.chr_write(txt[i]);
        pos(16'h0001, 16'h0001);
        cchk(8'h41, 1'b0);
        rchk("col", REG_COL, 16'h0002);
        cchk(8'h42, 1'b0);
        cchk(8'h43, 1'b0);
        cchk(CH_LF, 1'b1);
        rchk("col", REG_COL, 16'h0001);
        rchk("line", REG_LINE, 16'h0002);
        test_done();
    end
endmodule // tb_text_screen_buffer_controller
